/* include/lasu_pkg.sv */
// Constants and types for the conjunction and arithmetic shift unit
// Contract
// - Conjunction combines operands bitwise, writes destination
// - Address register direct never an operand
// - Conjunction flags: X kept, N/Z result, V/C cleared
// - Source locator: data modes only, immediate allowed
// - Destination locator: memory alterable modes only
// - Opmode picks data register or locator target
// - Immediate conjunction stores into destination, sized immediate
// - Size field: 00 byte, 01 word, 10 long
// - Immediate from low byte, word, or two words
// - Immediate conjunction destination: data alterable only
// - Flag-byte form ANDs immediate into flag byte
// - Immediate bits 4..0 clear X,N,Z,V,C when zero
// - Shift moves bits; carry holds last bit out
// - Immediate count ranges one through eight
// - Register count is register value modulo 64
// - Memory shift: one bit, word size only
// - Left shift: top bit to C and X, zero fill
// - Overflow reports any sign change during shift
// - Right shift replicates sign, low bit out to C/X
// - Zero count: X kept, C cleared
// - Count field zero means eight
// - Direction bit: 0 right, 1 left
package lasu_pkg;
  localparam logic [3:0] OP_AND_HI = 4'hC;
  localparam logic [3:0] OP_SHIFT_HI = 4'hE;
  localparam logic [7:0] OP_IMMC_HI = 8'h02;
  localparam logic [7:0] FLAGB_LO = 8'h3C;
  localparam logic [6:0] OP_MSHIFT_HI = 7'h70;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_RSVD = 2'h3;
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] EXT_ABSL = 3'h1;
  localparam logic [2:0] EXT_IMM = 3'h4;
  localparam int FLAG_X = 4;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [5:0] IMM_CNT_ZERO = 6'h08;
  localparam logic [5:0] MEM_SHIFT_CNT = 6'h01;
  localparam int APB_AW = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_RESULT = 12'h008;
  localparam logic [11:0] ADDR_ILLCNT = 12'h00C;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_ILL_BIT = 8;
  localparam int STAT_BUSY_BIT = 9;
  typedef enum logic [1:0] {LASU_IDLE = 2'b00, LASU_SHIFT = 2'b01} lasu_state_t;
  typedef enum logic [1:0] {WB_NONE = 2'h0, WB_DREG = 2'h1, WB_LOC = 2'h2, WB_SHREG = 2'h3} lasu_wb_t;
  typedef enum logic [2:0] {
    K_NONE = 3'h0, K_AND = 3'h1, K_IMMC = 3'h2, K_FLAGB = 3'h3, K_SHREG = 3'h4, K_SHMEM = 3'h5
  } lasu_kind_t;
endpackage

/* hdl/lasu_top.sv */
// Conjunction and arithmetic shift execution unit with APB status registers
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lasu_top
  import lasu_pkg::*;
(
  input wire logic mclk,                 // Core clock
  input wire logic rst,                  // Synchronous reset
  input wire logic [APB_AW-1:0] paddr,   // APB address
  input wire logic psel,                 // APB select
  input wire logic penable,              // APB enable
  input wire logic pwrite,               // APB direction
  input wire logic [31:0] pwdata,        // APB write data
  output logic [31:0] prdata,            // APB read data
  output logic pready,                   // APB ready
  output logic pslverr,                  // APB error
  input wire logic op_valid,             // Instruction offered
  output logic op_ready,                 // Unit can take instruction
  input wire logic [15:0] instr,         // Instruction word
  input wire logic [15:0] ext0,          // First extension word
  input wire logic [15:0] ext1,          // Second extension word
  input wire logic [31:0] dreg_val,      // Data register in bits 11:9
  input wire logic [31:0] locator_val,   // Located operand or shifted register
  input wire logic [4:0] flags_in,       // Current flag byte XNZVC
  output logic res_valid,                // Result pulse
  output logic [31:0] res_data,          // Result merged into target
  output lasu_wb_t res_target,           // Where result goes
  output logic res_write,                // Result must be written
  output logic [4:0] res_flags,          // New flag byte XNZVC
  output logic res_flags_write,          // Flags must be written
  output logic res_illegal               // Encoding rejected
);
  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: size_mask = 32'h000000FF;
      SZ_WORD: size_mask = 32'h0000FFFF;
      default: size_mask = 32'hFFFFFFFF;
    endcase
  endfunction

  function automatic logic [4:0] msb_idx(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: msb_idx = 5'h07;
      SZ_WORD: msb_idx = 5'h0F;
      default: msb_idx = 5'h1F;
    endcase
  endfunction

  lasu_state_t state_q;
  lasu_kind_t kind_q;
  logic [4:0] flags_in_q;
  logic [1:0] size_q;
  logic dir_q;
  logic [5:0] cnt_q;
  logic [5:0] cnt_left_q;
  logic [31:0] work_q;
  logic [31:0] orig_q;
  logic v_q;
  logic [31:0] ctrl_q;
  logic [31:0] ill_cnt_q;
  logic [31:0] prdata_q;
  logic valid_q, write_q, fwrite_q, ill_q;
  logic [31:0] data_q;
  logic [4:0] flags_q;
  lasu_wb_t target_q;

  // Field split
  wire [2:0] opmode = instr[8:6];
  wire [2:0] lmode = instr[5:3];
  wire [2:0] lreg = instr[2:0];
  wire accept = op_valid && op_ready;
  wire ctrl_en = ctrl_q[CTRL_EN_BIT];

  // Class decode
  wire is_and = instr[15:12] == OP_AND_HI && opmode != 3'h3 && opmode != 3'h7;
  wire is_flagb = instr[15:8] == OP_IMMC_HI && instr[7:0] == FLAGB_LO;
  wire is_immc = instr[15:8] == OP_IMMC_HI && !is_flagb;
  wire is_shreg = instr[15:12] == OP_SHIFT_HI && instr[7:6] != SZ_RSVD && instr[4:3] == 2'b00;
  wire is_shmem = instr[15:9] == OP_MSHIFT_HI && instr[7:6] == SZ_RSVD;
  wire lasu_kind_t kind_d = is_and ? K_AND : is_flagb ? K_FLAGB : is_immc ? K_IMMC :
                            is_shreg ? K_SHREG : is_shmem ? K_SHMEM : K_NONE;

  // Locator mode checks
  wire src_ok = lmode != MODE_AREG && (lmode != MODE_EXT || lreg <= EXT_IMM);
  wire mem_alt_ok = (lmode >= MODE_IND && lmode <= MODE_IDX) ||
                    (lmode == MODE_EXT && lreg <= EXT_ABSL);
  wire dalt_ok = lmode != MODE_AREG && (lmode != MODE_EXT || lreg <= EXT_ABSL);
  wire immc_ok = instr[7:6] != SZ_RSVD && dalt_ok;
  wire legal_d = ctrl_en && (
                 (kind_d == K_AND && (opmode[2] ? mem_alt_ok : src_ok)) ||
                 (kind_d == K_IMMC && immc_ok) ||
                 kind_d == K_FLAGB || kind_d == K_SHREG ||
                 (kind_d == K_SHMEM && mem_alt_ok));

  // Size and count selection
  wire [1:0] size_d = (kind_d == K_AND) ? opmode[1:0] :
                      (kind_d == K_SHMEM) ? SZ_WORD :
                      (kind_d == K_FLAGB) ? SZ_BYTE : instr[7:6];
  wire [5:0] imm_cnt = (instr[11:9] == 3'h0) ? IMM_CNT_ZERO : {3'h0, instr[11:9]};
  wire [5:0] cnt_d = (kind_d == K_SHMEM) ? MEM_SHIFT_CNT :
                     instr[5] ? dreg_val[5:0] : imm_cnt;
  wire [31:0] imm_val = (instr[7:6] == SZ_BYTE) ? {24'h000000, ext0[7:0]} :
                        (instr[7:6] == SZ_WORD) ? {16'h0000, ext0} : {ext0, ext1};

  // Conjunction path
  wire [31:0] lg_mask = size_mask(size_d);
  wire [31:0] lg_src = (kind_d == K_IMMC) ? imm_val : dreg_val;
  wire [31:0] lg_base = (kind_d == K_AND && !opmode[2]) ? dreg_val : locator_val;
  wire [31:0] lg_res = (lg_base & ~lg_mask) | (lg_src & locator_val & lg_mask);
  wire lg_n = lg_res[msb_idx(size_d)];
  wire lg_z = (lg_res & lg_mask) == 32'h00000000;
  wire [4:0] lg_flags = {flags_in[FLAG_X], lg_n, lg_z, 2'b00};
  wire [4:0] fb_flags = flags_in & ext0[4:0];
  wire lasu_wb_t lg_target = (kind_d == K_AND && !opmode[2]) ? WB_DREG : WB_LOC;

  // One shift step per cycle
  wire [4:0] mi = msb_idx(size_q);
  wire [31:0] sign_bit = 32'h00000001 << mi;
  wire [31:0] shl = work_q << 1;
  wire [31:0] shr = work_q >> 1;
  wire [31:0] shr_fix = work_q[mi] ? (shr | sign_bit) : (shr & ~sign_bit);
  wire step_out = dir_q ? work_q[mi] : work_q[0];
  wire [31:0] step_val = dir_q ? shl : shr_fix;
  wire step_vchg = dir_q && (shl[mi] != work_q[mi]);

  // Shift completion, either zero count at accept or last step
  wire in_shift = state_q == LASU_SHIFT;
  wire [1:0] fin_size = in_shift ? size_q : size_d;
  wire [31:0] fin_mask = size_mask(fin_size);
  wire [31:0] fin_orig = in_shift ? orig_q : locator_val;
  wire [31:0] fin_val = in_shift ? step_val : locator_val;
  wire [31:0] sh_res = (fin_orig & ~fin_mask) | (fin_val & fin_mask);
  wire sh_n = sh_res[msb_idx(fin_size)];
  wire sh_z = (sh_res & fin_mask) == 32'h00000000;
  wire sh_c = in_shift && step_out;
  wire sh_x = in_shift ? step_out : flags_in[FLAG_X];
  wire sh_v = in_shift && (v_q || step_vchg);
  wire [4:0] sh_flags = {sh_x, sh_n, sh_z, sh_v, sh_c};
  wire lasu_wb_t sh_target = ((in_shift ? kind_q : kind_d) == K_SHREG) ? WB_SHREG : WB_LOC;
  wire sh_done = in_shift ? (cnt_left_q == 6'h01) : (cnt_d == 6'h00);

  assign op_ready = state_q == LASU_IDLE;
  assign res_valid = valid_q;
  assign res_data = data_q;
  assign res_target = target_q;
  assign res_write = write_q;
  assign res_flags = flags_q;
  assign res_flags_write = fwrite_q;
  assign res_illegal = ill_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= LASU_IDLE;
      kind_q <= K_NONE;
      flags_in_q <= 5'h00;
      size_q <= SZ_BYTE;
      dir_q <= 1'b0;
      cnt_q <= 6'h00;
      cnt_left_q <= 6'h00;
      work_q <= 32'h00000000;
      orig_q <= 32'h00000000;
      v_q <= 1'b0;
      valid_q <= 1'b0;
      write_q <= 1'b0;
      fwrite_q <= 1'b0;
      ill_q <= 1'b0;
      data_q <= 32'h00000000;
      flags_q <= 5'h00;
      target_q <= WB_NONE;
    end else begin
      valid_q <= 1'b0;
      case (state_q)
        LASU_IDLE: begin
          if (accept) begin
            kind_q <= kind_d;
            flags_in_q <= flags_in;
            size_q <= size_d;
            dir_q <= instr[8];
            cnt_q <= cnt_d;
            cnt_left_q <= cnt_d;
            work_q <= locator_val;
            orig_q <= locator_val;
            v_q <= 1'b0;
            if (!legal_d) begin
              valid_q <= 1'b1;
              ill_q <= 1'b1;
              write_q <= 1'b0;
              fwrite_q <= 1'b0;
              flags_q <= flags_in;
              target_q <= WB_NONE;
            end else if (kind_d == K_AND || kind_d == K_IMMC || kind_d == K_FLAGB) begin
              valid_q <= 1'b1;
              ill_q <= 1'b0;
              write_q <= kind_d != K_FLAGB;
              fwrite_q <= 1'b1;
              data_q <= lg_res;
              flags_q <= (kind_d == K_FLAGB) ? fb_flags : lg_flags;
              target_q <= (kind_d == K_FLAGB) ? WB_NONE : lg_target;
            end else if (sh_done) begin
              valid_q <= 1'b1;
              ill_q <= 1'b0;
              write_q <= 1'b1;
              fwrite_q <= 1'b1;
              data_q <= sh_res;
              flags_q <= sh_flags;
              target_q <= sh_target;
            end else begin
              state_q <= LASU_SHIFT;
            end
          end
        end
        LASU_SHIFT: begin
          work_q <= step_val;
          v_q <= v_q || step_vchg;
          cnt_left_q <= cnt_left_q - 6'h01;
          if (sh_done) begin
            valid_q <= 1'b1;
            ill_q <= 1'b0;
            write_q <= 1'b1;
            fwrite_q <= 1'b1;
            data_q <= sh_res;
            flags_q <= sh_flags;
            target_q <= sh_target;
            state_q <= LASU_IDLE;
          end
        end
        default: state_q <= LASU_IDLE;
      endcase
    end
  end

  // APB slave, zero wait states, read data latched in setup phase
  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_status = paddr == ADDR_STATUS;
  wire hit_result = paddr == ADDR_RESULT;
  wire hit_ill = paddr == ADDR_ILLCNT;
  wire addr_hit = hit_ctrl || hit_status || hit_result || hit_ill;
  wire [31:0] status_word = {22'h000000, !op_ready, ill_q, 3'h0, flags_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q : hit_status ? status_word :
                       hit_result ? data_q : hit_ill ? ill_cnt_q : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_hit;
  assign prdata = prdata_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      ill_cnt_q <= 32'h00000000;
      prdata_q <= 32'h00000000;
    end else begin
      if (apb_setup) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      end
      if (apb_access && pwrite && hit_ctrl) begin
        ctrl_q <= {31'h00000000, pwdata[CTRL_EN_BIT]};
      end
      if (valid_q && ill_q) begin
        ill_cnt_q <= ill_cnt_q + 32'h00000001;
      end
    end
  end

  a_and_bitwise: assert property (@(posedge mclk) disable iff (rst)
    (accept && legal_d && kind_d == K_AND && opmode == 3'h2) |=>
      (res_valid && res_data == ($past(dreg_val) & $past(locator_val))))
    else $error("long conjunction result wrong");
  a_areg_reject: assert property (@(posedge mclk) disable iff (rst)
    (accept && is_and && lmode == MODE_AREG) |=> (res_valid && res_illegal))
    else $error("address register operand accepted");
  a_logic_flags: assert property (@(posedge mclk) disable iff (rst)
    (res_valid && !res_illegal && (kind_q == K_AND || kind_q == K_IMMC)) |->
      (res_flags[1:0] == 2'b00 && res_flags[FLAG_X] == flags_in_q[FLAG_X] &&
       res_flags[FLAG_Z] == ((res_data & size_mask(size_q)) == 32'h00000000)))
    else $error("conjunction flags wrong");
  a_src_imm_ok: assert property (@(posedge mclk) disable iff (rst)
    (accept && ctrl_en && is_and && !opmode[2] && lmode == MODE_EXT && lreg == EXT_IMM) |=>
      (res_valid && !res_illegal))
    else $error("immediate source rejected");
  a_dst_dreg_bad: assert property (@(posedge mclk) disable iff (rst)
    (accept && is_and && opmode[2] && lmode == MODE_DREG) |=> res_illegal)
    else $error("data register locator destination accepted");
  a_and_target: assert property (@(posedge mclk) disable iff (rst)
    (accept && legal_d && kind_d == K_AND) |=>
      (res_target == ($past(instr[8]) ? WB_LOC : WB_DREG)))
    else $error("conjunction target wrong");
  a_immc_byte: assert property (@(posedge mclk) disable iff (rst)
    (accept && legal_d && kind_d == K_IMMC && instr[7:6] == SZ_BYTE) |=>
      (res_data[7:0] == ($past(ext0[7:0]) & $past(locator_val[7:0])) &&
       res_data[31:8] == $past(locator_val[31:8])))
    else $error("byte immediate conjunction wrong");
  a_size_rsvd: assert property (@(posedge mclk) disable iff (rst)
    (accept && is_immc && instr[7:6] == SZ_RSVD) |=> res_illegal)
    else $error("reserved size accepted");
  a_flagb_and: assert property (@(posedge mclk) disable iff (rst)
    (accept && legal_d && kind_d == K_FLAGB) |=>
      (res_flags == ($past(flags_in) & $past(ext0[4:0])) && !res_write))
    else $error("flag byte conjunction wrong");
  a_cnt_eight: assert property (@(posedge mclk) disable iff (rst)
    (accept && legal_d && kind_d == K_SHREG && !instr[5] && instr[11:9] == 3'h0) |=>
      (in_shift && cnt_left_q == 6'h08) ##8 res_valid)
    else $error("zero count field not eight steps");
  a_reg_cnt_mod: assert property (@(posedge mclk) disable iff (rst)
    (accept && legal_d && kind_d == K_SHREG && instr[5]) |=> (cnt_q == $past(dreg_val[5:0])))
    else $error("register count not modulo 64");
  a_mem_one_bit: assert property (@(posedge mclk) disable iff (rst)
    (accept && legal_d && kind_d == K_SHMEM) |=>
      (in_shift && cnt_left_q == 6'h01 && size_q == SZ_WORD) ##1 res_valid)
    else $error("memory shift not one word bit");
  a_left_xc: assert property (@(posedge mclk) disable iff (rst)
    (res_valid && !res_illegal && kind_q == K_SHREG && dir_q && cnt_q != 6'h00) |->
      (res_flags[FLAG_X] == res_flags[FLAG_C]))
    else $error("left shift X and C differ");
  a_right_novf: assert property (@(posedge mclk) disable iff (rst)
    (res_valid && !res_illegal && (kind_q == K_SHREG || kind_q == K_SHMEM) && !dir_q) |->
      !res_flags[FLAG_V])
    else $error("right shift reported overflow");
  a_zero_cnt: assert property (@(posedge mclk) disable iff (rst)
    (res_valid && !res_illegal && kind_q == K_SHREG && cnt_q == 6'h00) |->
      (!res_flags[FLAG_C] && res_flags[FLAG_X] == flags_in_q[FLAG_X]))
    else $error("zero count flags wrong");
  a_illegal_quiet: assert property (@(posedge mclk) disable iff (rst)
    (res_valid && res_illegal) |-> (!res_write && !res_flags_write))
    else $error("illegal encoding modified state");
endmodule
`default_nettype wire

/* tb/lasu_seq_model.sv */
// Sequencer and operand-fetch model that offers instructions to the unit
`timescale 1ns/1ps
`default_nettype none
module lasu_seq_model
  import lasu_pkg::*;
(
  input wire logic mclk,            // Core clock
  input wire logic op_ready,        // Unit can take instruction
  input wire logic res_valid,       // Result pulse
  output logic op_valid,            // Instruction offered
  output logic [15:0] instr,        // Instruction word
  output logic [15:0] ext0,         // First extension word
  output logic [15:0] ext1,         // Second extension word
  output logic [31:0] dreg_val,     // Data register value
  output logic [31:0] locator_val,  // Located operand value
  output logic [4:0] flags_in       // Current flags
);
  int lat;
  initial begin
    op_valid = 1'b0;
    {instr, ext0, ext1, dreg_val, locator_val, flags_in} = '1;
  end
  // Offer after gap idle cycles, hold until taken, then wait for the result
  // Waits have no cap of their own; only the bench timeout ends a hang
  task automatic issue(input logic [15:0] i, e0, e1, input logic [31:0] d, l, input logic [4:0] f, input int gap);
    repeat (gap + 1) @(posedge mclk);
    {op_valid, instr, ext0, ext1, dreg_val, locator_val, flags_in} <= {1'b1, i, e0, e1, d, l, f};
    @(negedge mclk);
    while (op_ready !== 1'b1) begin
      @(negedge mclk);
    end
    @(posedge mclk);
    op_valid <= 1'b0;
    // Operands are stale once taken, so show their inverse rather than hold them
    {instr, ext0, ext1, dreg_val, locator_val, flags_in} <= ~{i, e0, e1, d, l, f};
    lat = 0;
    while (res_valid !== 1'b1) begin
      @(negedge mclk);
      lat++;
    end
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench for the conjunction and arithmetic shift unit
`timescale 1ns/1ps
`default_nettype none
module testbench
  import lasu_pkg::*;
;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, op_valid, op_ready, res_valid;
  logic res_write, res_flags_write, res_illegal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dreg_val, locator_val, res_data, rd;
  logic [15:0] instr, ext0, ext1;
  logic [4:0] flags_in, res_flags;
  lasu_wb_t res_target;
  logic er;
  int err_total, compares, cyc;
  localparam logic [16:0] ILL_TAB [16] = '{17'h1C049, 17'h1C100, 17'h1C1BA, 17'h1C17C, 17'h102D3, 17'h10248,
    17'h102BA, 17'h1E1C0, 17'h1E1FC, 17'h1E0FA, 17'h1C149, 17'h1E10D, 17'h0C0BC, 17'h0C0BA, 17'h0C0BB, 17'h0C080};
  localparam logic [79:0] SH_TAB [10] = '{{16'hE305, 32'h0, 32'h00000040}, {16'hE145, 32'h0, 32'h000000C3},
    {16'hE685, 32'h0, 32'h80000013}, {16'hE465, 32'h42, 32'h00008005}, {16'hE5A5, 32'h40, 32'h12345678},
    {16'hE525, 32'h28, 32'h00000081}, {16'hEE05, 32'h0, 32'hFFFFFF7F}, {16'hE585, 32'h0, 32'hC0000001},
    {16'hE1D0, 32'h0, 32'h1234C001}, {16'hE0D0, 32'h0, 32'hABCD4003}};

  lasu_top dut_u (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
    .op_ready(op_ready), .instr(instr), .ext0(ext0), .ext1(ext1), .dreg_val(dreg_val),
    .locator_val(locator_val), .flags_in(flags_in), .res_valid(res_valid), .res_data(res_data),
    .res_target(res_target), .res_write(res_write), .res_flags(res_flags),
    .res_flags_write(res_flags_write), .res_illegal(res_illegal));
  lasu_seq_model seq_u (.mclk(mclk), .op_ready(op_ready), .res_valid(res_valid), .op_valid(op_valid),
    .instr(instr), .ext0(ext0), .ext1(ext1), .dreg_val(dreg_val), .locator_val(locator_val),
    .flags_in(flags_in));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] msk(input logic [1:0] sz);
    return (sz == 2'h0) ? 32'h000000FF : (sz == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
  endfunction
  function automatic logic [4:0] nz(input logic [31:0] v, input logic [1:0] sz, input logic x);
    return {x, |(v & msk(sz) & ~(msk(sz) >> 1)), (v & msk(sz)) == 32'h0, 2'b00};
  endfunction
  // Step-by-step shift reference: flags in the top five bits, merged result below
  function automatic logic [36:0] shm(input logic [31:0] v, input logic [1:0] sz, input logic left, input int n,
    input logic x);
    logic [31:0] m, t, top;
    logic o, vf;
    m = msk(sz);
    top = m & ~(m >> 1);
    t = v & m;
    o = 1'b0;
    vf = 1'b0;
    for (int k = 0; k < n; k++) begin
      o = left ? |(t & top) : t[0];
      t = left ? (t << 1) & m : (t >> 1) | (t & top);
      vf = vf | (left && ((|(t & top)) != o));
    end
    return {(n == 0) ? x : o, |(t & top), t == 32'h0, vf, (n == 0) ? 1'b0 : o, (v & ~m) | t};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic exp_res(input string nm, input logic [31:0] d, input lasu_wb_t t, input logic [4:0] f,
    input int lat);
    chk({nm, " data"}, d, res_data);
    chk({nm, " target"}, {30'h0, t}, {30'h0, res_target});
    chk({nm, " writes"}, 32'h3, {30'h0, res_write, res_flags_write});
    chk({nm, " flags"}, {27'h0, f}, {27'h0, res_flags});
    chk({nm, " illegal"}, 32'h0, {31'h0, res_illegal});
    chk({nm, " latency"}, 32'(lat), 32'(seq_u.lat));
  endtask

  task automatic t_regs;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0);
      chk("reset value", (k == 0) ? CTRL_RESET : 32'h0, rd);
      chk("slverr", 32'h0, {31'h0, er});
    end
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped slverr", 32'h1, {31'h0, er});
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b1, ADDR_RESULT, 32'hFFFFFFFF);
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("read-only result", 32'h0, rd);
    $display("test regs done");
  endtask
  task automatic t_and;
    logic [2:0] om;
    logic [31:0] o, v;
    for (int k = 0; k < 6; k++) begin
      om = k[2:0] + ((k > 2) ? 3'h1 : 3'h0);
      seq_u.issue({4'hC, 3'h1, om, 3'h2, 3'h3}, 16'h0, 16'h0, 32'h80008080, 32'hC0FF80F0, 5'h13, k);
      o = om[2] ? 32'hC0FF80F0 : 32'h80008080;
      v = 32'h80008080 & 32'hC0FF80F0;
      exp_res("and", (o & ~msk(om[1:0])) | (v & msk(om[1:0])), om[2] ? WB_LOC : WB_DREG, nz(v, om[1:0], 1'b1), 1);
    end
    seq_u.issue(16'hC080, 16'h0, 16'h0, 32'h000000F0, 32'h0000000F, 5'h0F, 0);
    exp_res("and zero", 32'h0, WB_DREG, 5'h04, 1);
    $display("test and done");
  endtask
  task automatic t_ill;
    logic [31:0] c0;
    apb(1'b0, ADDR_ILLCNT, 32'h0);
    c0 = rd;
    foreach (ILL_TAB[k]) begin
      seq_u.issue(ILL_TAB[k][15:0], 16'h0, 16'h0, 32'h5, 32'h9, 5'h15, 0);
      chk("illegal", {31'h0, ILL_TAB[k][16]}, {31'h0, res_illegal});
      chk("write", {31'h0, !ILL_TAB[k][16]}, {31'h0, res_write});
      if (ILL_TAB[k][16]) chk("kept flags", 32'h15, {27'h0, res_flags});
    end
    apb(1'b0, ADDR_ILLCNT, 32'h0);
    chk("illegal count", c0 + 32'h0000000C, rd);
    $display("test illegal done");
  endtask
  task automatic t_immc;
    logic [31:0] im, v;
    for (int s = 0; s < 3; s++) begin
      im = (s == 2) ? 32'hA5C30F81 : 32'hA5C3A5C3;
      v = im & 32'hF3E19C7F;
      seq_u.issue({8'h02, s[1:0], 3'h2, 3'h3}, 16'hA5C3, 16'h0F81, 32'h0, 32'hF3E19C7F, 5'h0B, 2);
      exp_res("immc", (32'hF3E19C7F & ~msk(s[1:0])) | (v & msk(s[1:0])), WB_LOC, nz(v, s[1:0], 1'b0), 1);
    end
    for (int k = 0; k < 6; k++) begin
      seq_u.issue(16'h023C, {8'h0, ~(8'h01 << k)}, 16'h0, 32'h0, 32'h0, (k == 5) ? 5'h0A : 5'h1F, 0);
      chk("flag byte", {27'h0, ((k == 5) ? 5'h0A : 5'h1F) & ~(5'h01 << k)}, {27'h0, res_flags});
      chk("flag write", 32'h1, {31'h0, res_flags_write});
      chk("flag no operand write", 32'h0, {31'h0, res_write});
    end
    $display("test immediate done");
  endtask
  task automatic t_shift;
    logic [15:0] i;
    logic [36:0] e;
    logic [1:0] sz;
    int n;
    foreach (SH_TAB[k]) begin
      i = SH_TAB[k][79:64];
      sz = (i[7:6] == 2'h3) ? SZ_WORD : i[7:6];
      n = (i[7:6] == 2'h3) ? 1 : i[5] ? int'(SH_TAB[k][37:32]) : ((i[11:9] == 3'h0) ? 8 : int'(i[11:9]));
      e = shm(SH_TAB[k][31:0], sz, i[8], n, 1'b1);
      seq_u.issue(i, 16'h0, 16'h0, SH_TAB[k][63:32], SH_TAB[k][31:0], 5'h11, 0);
      exp_res("shift", e[31:0], (i[7:6] == 2'h3) ? WB_LOC : WB_SHREG, e[36:32], n + 1);
    end
    // Long shift with a status read while the unit is busy
    e = shm(32'h00000081, SZ_BYTE, 1'b1, 40, 1'b1);
    fork
      seq_u.issue(16'hE525, 16'h0, 16'h0, 32'h00000028, 32'h00000081, 5'h11, 0);
      begin
        repeat (6) @(posedge mclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
      end
    join
    chk("status busy", 32'h1, {31'h0, rd[STAT_BUSY_BIT]});
    exp_res("busy shift", e[31:0], WB_SHREG, e[36:32], 41);
    $display("test shift done");
  endtask
  task automatic t_disable;
    apb(1'b1, ADDR_CTRL, 32'h0);
    seq_u.issue(16'hC080, 16'h0, 16'h0, 32'h3, 32'h6, 5'h07, 0);
    chk("disabled illegal", 32'h1, {31'h0, res_illegal});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status illegal", 32'h1, {31'h0, rd[STAT_ILL_BIT]});
    apb(1'b1, ADDR_CTRL, 32'h1);
    seq_u.issue(16'hC080, 16'h0, 16'h0, 32'h80000003, 32'hC0000006, 5'h17, 0);
    exp_res("enabled", 32'h80000002, WB_DREG, 5'h18, 1);
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("result reg", 32'h80000002, rd);
    $display("test disable done");
  endtask

  task automatic results;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk);
      cyc++;
      if (cyc == 20000) begin
        err_total++;
        results();
      end
    end
  end

  initial begin
    err_total = 0;
    compares = 0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_and();
    t_ill();
    t_immc();
    t_shift();
    t_disable();
    results();
  end
endmodule
`default_nettype wire
